// file: port_ctrl_regs.vh
// register offsets, field positions and clock figures for the port block
// assumes byte-wide registers, one per aligned avalon word
`ifndef PORT_CTRL_REGS_VH
`define PORT_CTRL_REGS_VH
// printed offsets are register indexes; byte address is four times index
`define IDX_PC_DATA   4'h0
`define IDX_PC_DIR    4'h1
`define IDX_PC_OPT    4'h2
`define IDX_PB_DATA   4'h4
`define IDX_PB_DIR    4'h5
`define IDX_PB_OPT    4'h6
`define IDX_PA_DATA   4'h8
`define IDX_PA_DIR    4'h9
`define IDX_PA_OPT    4'ha
`define IDX_MISC1     4'hc
`define IDX_MISC2     4'hd
`define REG_RESET     8'h00
`define MISC1_G1_HI   7
`define MISC1_G1_LO   6
`define MISC1_CKOUT   5
`define MISC1_G0_HI   4
`define MISC1_G0_LO   3
`define MISC1_DIV_HI  2
`define MISC1_DIV_LO  1
`define MISC1_SLOW    0
`define MISC1_SENSE_MASK 8'hd8
`define MISC2_MASK    8'h0f
`define MISC2_MOK     3
`define MISC2_SOK     2
`define MISC2_SSRC    1
`define MISC2_SSLV    0
`define SENSE_FALL_LOW 2'b00
`define SENSE_RISE     2'b01
`define SENSE_FALL     2'b10
`define SENSE_BOTH     2'b11
// cpu clock divide codes: half the oscillator ratio minus one, half-period counts
`define DIV_NORMAL    5'd0
`define DIV_BY4       5'd1
`define DIV_BY8       5'd3
`define DIV_BY16      5'd7
`define DIV_BY32      5'd15
`endif

// file: port_ctrl.v
// three 8-bit ports, interrupt sense and clock/spi pin control registers
// assumes an avalon-mm master, pins synchronous to ref_clk_i
//
// How it works
// (RQ1) direction bit: 0 input, 1 output
// (RQ2) input option: 0 floating, 1 pull-up
// (RQ3) output option: 0 open drain, 1 push-pull
// (RQ4) pins without option use direction only
// (RQ5) reset clears all registers, pins float
// (RQ6) port blocks at printed offsets c, b, a
// (RQ7) four pin event kinds per interrupt group
// (RQ8) bits 7:6 set group one sense
// (RQ9) bits 4:3 set group zero sense
// (RQ10) sense writes only when mask bit set
// (RQ11) software changes sense only while masked
// (RQ12) bit 5 puts cpu clock on pin
// (RQ13) slow divider picks /4 /8 /16 /32
// (RQ14) slow select off gives oscillator/2
// (RQ15) second register upper nibble reads zero
// (RQ16) bit 3 kills spi master output
// (RQ17) bit 2 kills spi slave output
// (RQ18) bit 1 picks select level source
// (RQ19) soft select frees select pin
// (RQ20) bit 0 is the soft select level
// (RQ21) data writes stored; reads mux latch/pin
// (RQ22) byte registers, no read side effects
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ns
`include "port_ctrl_regs.vh"
module port_ctrl (
  input  wire        ref_clk_i,
  input  wire        rst_i,
  input  wire [5:0]  address_i,
  input  wire        read_i,
  input  wire        write_i,
  input  wire [31:0] writedata_i,
  input  wire [3:0]  byteenable_i,
  output reg  [31:0] readdata_o,
  output reg         waitrequest_o,
  input  wire        irq_masked_i,
  input  wire [7:0]  pa_pin_i,
  input  wire [7:0]  pb_pin_i,
  input  wire [7:0]  pc_pin_i,
  output reg  [7:0]  pa_out_o,
  output reg  [7:0]  pa_oe_o,
  output reg  [7:0]  pa_pullup_o,
  output reg  [7:0]  pb_out_o,
  output reg  [7:0]  pb_oe_o,
  output reg  [7:0]  pb_pullup_o,
  output reg  [7:0]  pc_out_o,
  output reg  [7:0]  pc_oe_o,
  output reg  [7:0]  pc_pullup_o,
  input  wire        spi_master_out_i,
  input  wire        spi_master_out_en_i,
  input  wire        spi_slave_out_i,
  input  wire        spi_slave_out_en_i,
  output reg         spi_select_level_o,
  output reg         ext_irq_group_zero_o,
  output reg         ext_irq_group_one_o,
  input  wire        ext_irq_source_option_i,
  output reg         cpu_clk_o
);

  // ***********************************************************
  //  registers
  // ***********************************************************
  // pins 6 and 4 of port a carry no option bit
  parameter [7:0] PA_HAS_OPTION = 8'haf;

  reg [7:0]  data_reg  [0:2];
  reg [7:0]  dir_reg   [0:2];
  reg [7:0]  opt_reg   [0:2];
  reg [7:0]  misc1_reg;
  reg [7:0]  misc2_reg;
  reg [7:0]  pin_prev_reg [0:2];
  reg        ack_reg;
  reg [4:0]  div_cnt_reg;
  reg [4:0]  div_next;
  reg [7:0]  rd_next;
  reg        irq0_next;
  reg        irq1_next;

  wire [3:0] idx = address_i[5:2];
  wire       req = (read_i | write_i) & ~ack_reg;
  // writes land only on the edge that sees waitrequest low
  wire       wr  = write_i & ~waitrequest_o & byteenable_i[0];
  wire [7:0] wd  = writedata_i[7:0];
  wire [7:0] pins [0:2];
  wire [7:0] has_opt [0:2];
  wire [7:0] rd_port [0:2];
  wire [7:0] fire [0:2];
  wire       ss_soft = misc2_reg[`MISC2_SSRC];
  wire       clk_out = misc1_reg[`MISC1_CKOUT];
  assign pins[0] = pc_pin_i;
  assign pins[1] = pb_pin_i;
  assign pins[2] = pa_pin_i;
  assign has_opt[0] = 8'hff;
  assign has_opt[1] = 8'hff;
  assign has_opt[2] = PA_HAS_OPTION;

  // ***********************************************************
  //  per-port logic: index 0 port c, 1 port b, 2 port a
  // ***********************************************************
  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1) begin : g_port
      wire [31:0] base_full = p * 4;
      // only the low bits index a word
      wire [3:0]  base = base_full[3:0];
      // (RQ6) block decode per port
      wire hit_d = wr & (idx == base);
      wire hit_r = wr & (idx == base + 4'h1);
      wire hit_o = wr & (idx == base + 4'h2);
      // (RQ21) latch or pin
      assign rd_port[p] = (dir_reg[p] & data_reg[p])
                        | (~dir_reg[p] & pins[p]);
      // port c follows the group it joins
      wire [1:0] sense = (p == 2) ? misc1_reg[`MISC1_G0_HI:`MISC1_G0_LO]
                       : (p == 1) ? misc1_reg[`MISC1_G1_HI:`MISC1_G1_LO]
                       : ext_irq_source_option_i
                         ? misc1_reg[`MISC1_G1_HI:`MISC1_G1_LO]
                         : misc1_reg[`MISC1_G0_HI:`MISC1_G0_LO];
      wire [7:0] irq_en = ~dir_reg[p] & opt_reg[p];
      wire [7:0] fall = pin_prev_reg[p] & ~pins[p];
      wire [7:0] rise = ~pin_prev_reg[p] & pins[p];
      // (RQ7) event kinds per sense code
      assign fire[p] = irq_en & (
        (sense == `SENSE_FALL_LOW) ? (fall | ~pins[p]) :
        (sense == `SENSE_RISE)     ? rise :
        (sense == `SENSE_FALL)     ? fall : (rise | fall));

      // (RQ21) always stored
      always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
          // (RQ5) all zeros
          data_reg[p] <= `REG_RESET;
        end else if (hit_d) begin
          data_reg[p] <= wd;
        end
      end

      // (RQ1) independent bits
      always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
          // (RQ5) pins float
          dir_reg[p] <= `REG_RESET;
        end else if (hit_r) begin
          dir_reg[p] <= wd;
        end
      end

      // (RQ4) unimplemented option bits
      always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
          opt_reg[p] <= `REG_RESET;
        end else if (hit_o) begin
          opt_reg[p] <= wd & has_opt[p];
        end
      end

      // reset high; interrupt enables are off then anyway
      always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
          pin_prev_reg[p] <= 8'hff;
        end else begin
          pin_prev_reg[p] <= pins[p];
        end
      end
    end
  endgenerate

  // ***********************************************************
  //  bus slave: one wait cycle, then answer
  // ***********************************************************
  always @* begin
    case (idx)
      `IDX_PC_DATA: rd_next = rd_port[0];
      `IDX_PC_DIR:  rd_next = dir_reg[0];
      `IDX_PC_OPT:  rd_next = opt_reg[0];
      `IDX_PB_DATA: rd_next = rd_port[1];
      `IDX_PB_DIR:  rd_next = dir_reg[1];
      `IDX_PB_OPT:  rd_next = opt_reg[1];
      `IDX_PA_DATA: rd_next = rd_port[2];
      `IDX_PA_DIR:  rd_next = dir_reg[2];
      `IDX_PA_OPT:  rd_next = opt_reg[2];
      `IDX_MISC1:   rd_next = misc1_reg;
      // (RQ15) upper nibble zero
      `IDX_MISC2:   rd_next = misc2_reg & `MISC2_MASK;
      default:      rd_next = 8'h00;
    endcase
  end

  // waitrequest drops one cycle after request, for one edge
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_reg       <= 1'b0;
      waitrequest_o <= 1'b1;
    end else begin
      ack_reg       <= req;
      waitrequest_o <= ~req;
    end
  end

  // (RQ22) reads have no side effects
  // taken one edge early so data stand while waitrequest is low
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      readdata_o <= 32'h00000000;
    end else if (read_i & req) begin
      readdata_o <= {24'h000000, rd_next};
    end
  end

  // (RQ10) sense fields guarded
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      misc1_reg <= `REG_RESET;
    end else if (wr & (idx == `IDX_MISC1)) begin
      if (irq_masked_i) begin
        misc1_reg <= wd;
      end else begin
        misc1_reg <= (misc1_reg & `MISC1_SENSE_MASK)
                   | (wd & ~`MISC1_SENSE_MASK);
      end
    end
  end

  // (RQ15) reserved nibble never stored
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      misc2_reg <= `REG_RESET;
    end else if (wr & (idx == `IDX_MISC2)) begin
      misc2_reg <= wd & `MISC2_MASK;
    end
  end

  // ***********************************************************
  //  cpu clock divider
  // ***********************************************************
  always @* begin
    // (RQ14) normal oscillator/2
    if (!misc1_reg[`MISC1_SLOW]) begin
      div_next = `DIV_NORMAL;
    end else begin
      // (RQ13) slow divider codes
      case (misc1_reg[2:1])
        2'b00:   div_next = `DIV_BY4;
        2'b10:   div_next = `DIV_BY8;
        2'b01:   div_next = `DIV_BY16;
        default: div_next = `DIV_BY32;
      endcase
    end
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt_reg <= 5'd0;
      cpu_clk_o   <= 1'b0;
    end else if (div_cnt_reg >= div_next) begin
      div_cnt_reg <= 5'd0;
      cpu_clk_o   <= ~cpu_clk_o;
    end else begin
      div_cnt_reg <= div_cnt_reg + 5'd1;
    end
  end

  // ***********************************************************
  //  pin drivers and interrupt outputs
  // ***********************************************************
  reg [7:0]  pa_out_next;
  reg [7:0]  pa_oe_next;
  reg [7:0]  pa_pullup_next;
  reg [7:0]  pb_out_next;
  reg [7:0]  pb_oe_next;
  reg [7:0]  pb_pullup_next;
  reg [7:0]  pc_out_next;
  reg [7:0]  pc_oe_next;
  reg [7:0]  pc_pullup_next;
  reg        select_next;

  always @* begin
    irq0_next = |fire[2];
    irq1_next = |fire[1];
    // port c joins a group by source option
    if (ext_irq_source_option_i) begin
      irq1_next = irq1_next | (|fire[0]);
    end else begin
      irq0_next = irq0_next | (|fire[0]);
    end
  end

  // (RQ1) (RQ3) open drain drives low only, push-pull both
  always @* begin
    pa_out_next    = data_reg[2];
    pa_oe_next     = dir_reg[2] & (opt_reg[2] | ~data_reg[2]);
    // (RQ2) pull-up on inputs with option
    pa_pullup_next = ~dir_reg[2] & opt_reg[2] & PA_HAS_OPTION;
  end

  // alternate functions take the pin over the port setting
  always @* begin
    pb_out_next    = data_reg[1];
    pb_oe_next     = dir_reg[1] & (opt_reg[1] | ~data_reg[1]);
    pb_pullup_next = ~dir_reg[1] & opt_reg[1];
    // (RQ16) master output kill
    if (spi_master_out_en_i & ~misc2_reg[`MISC2_MOK]) begin
      pb_out_next[4] = spi_master_out_i;
      pb_oe_next[4]  = 1'b1;
    end
    // (RQ17) slave output kill
    if (spi_slave_out_en_i & ~misc2_reg[`MISC2_SOK]) begin
      pb_out_next[5] = spi_slave_out_i;
      pb_oe_next[5]  = 1'b1;
    end
  end

  // clock out lags the divider one edge, fine for a monitor pin
  always @* begin
    pc_out_next    = data_reg[0];
    pc_oe_next     = dir_reg[0] & (opt_reg[0] | ~data_reg[0]);
    pc_pullup_next = ~dir_reg[0] & opt_reg[0];
    // (RQ12) cpu clock on pin
    if (clk_out) begin
      pc_out_next[2] = cpu_clk_o;
      pc_oe_next[2]  = 1'b1;
    end
  end

  // (RQ18) (RQ19) (RQ20) select level source; pin left to port
  always @* begin
    if (ss_soft) begin
      select_next = misc2_reg[`MISC2_SSLV];
    end else begin
      select_next = pb_pin_i[7];
    end
  end

  // every pin output straight from a flip-flop
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pa_out_o <= 8'h00;
      pa_oe_o <= 8'h00;
      pa_pullup_o <= 8'h00;
      pb_out_o <= 8'h00;
      pb_oe_o <= 8'h00;
      pb_pullup_o <= 8'h00;
      pc_out_o <= 8'h00;
      pc_oe_o <= 8'h00;
      pc_pullup_o <= 8'h00;
      spi_select_level_o <= 1'b1;
      ext_irq_group_zero_o <= 1'b0;
      ext_irq_group_one_o <= 1'b0;
    end else begin
      pa_out_o <= pa_out_next;
      pa_oe_o <= pa_oe_next;
      pa_pullup_o <= pa_pullup_next;
      pb_out_o <= pb_out_next;
      pb_oe_o <= pb_oe_next;
      pb_pullup_o <= pb_pullup_next;
      pc_out_o <= pc_out_next;
      pc_oe_o <= pc_oe_next;
      pc_pullup_o <= pc_pullup_next;
      spi_select_level_o <= select_next;
      // (RQ8) (RQ9) group sense applied
      ext_irq_group_zero_o <= irq0_next;
      ext_irq_group_one_o  <= irq1_next;
    end
  end

endmodule // port_ctrl

// file: port_ctrl_chk.sv
// checker: bus handshake and pin control relations of port_ctrl
// assumes bind onto port_ctrl, one clock, async active-high reset
`timescale 1ns/1ns
module port_ctrl_chk #(parameter [7:0] PA_HAS_OPTION = 8'haf) (
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic [5:0]  address_i,
  input wire logic        read_i,
  input wire logic        write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0]  byteenable_i,
  input wire logic [31:0] readdata_o,
  input wire logic        waitrequest_o,
  input wire logic [7:0]  pa_oe_o,
  input wire logic [7:0]  pb_oe_o,
  input wire logic [7:0]  pc_oe_o,
  input wire logic [7:0]  pa_pullup_o,
  input wire logic [7:0]  pb_pullup_o,
  input wire logic [7:0]  pc_pullup_o,
  input wire logic        spi_select_level_o
);
  // **********
  // properties
  // **********
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; (read_i || write_i) && waitrequest_o; endsequence
  sequence s_ack; !waitrequest_o ##1 waitrequest_o; endsequence
  sequence s_rd; read_i && !waitrequest_o; endsequence
  sequence s_ss; write_i && !waitrequest_o && address_i == 6'h34 &&
    byteenable_i[0] && writedata_i[1:0] == 2'b11; endsequence
  property p_req_ack; s_req |=> s_ack; endproperty
  a_req_ack: assert property (p_req_ack) else $error("bad ack");
  property p_hi_zero; s_rd |-> readdata_o[31:8] == 24'h0; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("wide read");
  property p_res_zero;
    s_rd ##0 (address_i == 6'h34) |-> readdata_o[7:4] == 4'h0;
  endproperty
  a_res_zero: assert property (p_res_zero) else $error("reserved");
  property p_unmapped;
    s_rd ##0 (address_i == 6'h0c) |-> readdata_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped");
  property p_pull_out;
    ((pa_oe_o & pa_pullup_o) | (pb_oe_o & pb_pullup_o) |
     (pc_oe_o & pc_pullup_o)) == 8'h00;
  endproperty
  a_pull_out: assert property (p_pull_out) else $error("pull on out");
  property p_no_opt; (pa_pullup_o & ~PA_HAS_OPTION) == 8'h00; endproperty
  a_no_opt: assert property (p_no_opt) else $error("pull no opt");
  property p_reset;
    $past(rst_i) |-> {pa_oe_o, pb_oe_o, pc_oe_o, pa_pullup_o, pb_pullup_o,
                      pc_pullup_o} == 48'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("not floating");
  property p_soft_ss; s_ss |-> ##[0:2] spi_select_level_o; endproperty
  a_soft_ss: assert property (p_soft_ss) else $error("soft ss");
endmodule // port_ctrl_chk
bind port_ctrl port_ctrl_chk #(.PA_HAS_OPTION(PA_HAS_OPTION)) chk_i (
  .ref_clk_i, .rst_i, .address_i, .read_i, .write_i, .writedata_i,
  .byteenable_i, .readdata_o, .waitrequest_o, .pa_oe_o, .pb_oe_o, .pc_oe_o,
  .pa_pullup_o, .pb_pullup_o, .pc_pullup_o, .spi_select_level_o);

// file: pad_model.sv
// pad and outside world of one 8-bit port
// assumes the bench gives the outside level and whether it drives
`timescale 1ns/1ns
module pad_model (
  input  wire logic       ref_clk_i,
  input  wire logic [7:0] out_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] pullup_i,
  input  wire logic [7:0] ext_en_i,
  input  wire logic [7:0] ext_val_i,
  output wire logic [7:0] pin_o
);
  logic [7:0] alt = 8'h00;
  // undriven unpulled pins wander, never hold a stale level
  always @(posedge ref_clk_i) alt <= ~alt;
  assign pin_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_val_i) |
                 (~oe_i & ~ext_en_i & (pullup_i | alt));
endmodule // pad_model

// file: tb.sv
// bench: register access, pin modes, sense, divider and spi overrides
// assumes pad_model on each port and the checker bound in
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  fail_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, read_i = 1'b0, write_i = 1'b0;
  logic [5:0] address_i = 6'h00;
  logic [31:0] writedata_i = 32'h0;
  logic [3:0] byteenable_i = 4'h0, spi = 4'h0;
  logic irq_masked_i = 1'b1, src = 1'b0;
  logic [23:0] ext = 24'h3ca5c3;
  int fail_count = 0, check_count = 0;
  logic [15:0] dv [6] = '{16'h4020, 16'h2021, 16'h1025, 16'h0823,
                          16'h0427, 16'h4026};
  wire [31:0] readdata_o;
  wire waitrequest_o, spi_select_level_o, cpu_clk_o, irq0, irq1;
  wire [7:0] pa_pin_i, pb_pin_i, pc_pin_i, pa_out_o, pb_out_o, pc_out_o;
  wire [7:0] pa_oe_o, pb_oe_o, pc_oe_o, pa_pullup_o, pb_pullup_o, pc_pullup_o;
  wire [23:0] oe_all = {pc_oe_o, pb_oe_o, pa_oe_o};
  wire [23:0] pu_all = {pc_pullup_o, pb_pullup_o, pa_pullup_o};
  wire [23:0] out_all = {pc_out_o, pb_out_o, pa_out_o};
  always #50 ref_clk_i = ~ref_clk_i;
  port_ctrl #(.PA_HAS_OPTION(8'haf)) port_ctrl_i (.ref_clk_i, .rst_i,
    .address_i, .read_i, .write_i, .writedata_i, .byteenable_i, .readdata_o,
    .waitrequest_o, .irq_masked_i, .pa_pin_i, .pb_pin_i, .pc_pin_i,
    .pa_out_o, .pa_oe_o, .pa_pullup_o, .pb_out_o, .pb_oe_o, .pb_pullup_o,
    .pc_out_o, .pc_oe_o, .pc_pullup_o, .spi_master_out_i(spi[3]),
    .spi_master_out_en_i(spi[2]), .spi_slave_out_i(spi[1]),
    .spi_slave_out_en_i(spi[0]), .spi_select_level_o,
    .ext_irq_group_zero_o(irq0), .ext_irq_group_one_o(irq1),
    .ext_irq_source_option_i(src), .cpu_clk_o);
  pad_model pad_a_i (.ref_clk_i, .out_i(pa_out_o), .oe_i(pa_oe_o),
    .pullup_i(pa_pullup_o), .ext_en_i(8'hff), .ext_val_i(ext[7:0]),
    .pin_o(pa_pin_i));
  pad_model pad_b_i (.ref_clk_i, .out_i(pb_out_o), .oe_i(pb_oe_o),
    .pullup_i(pb_pullup_o), .ext_en_i(8'hff), .ext_val_i(ext[15:8]),
    .pin_o(pb_pin_i));
  pad_model pad_c_i (.ref_clk_i, .out_i(pc_out_o), .oe_i(pc_oe_o),
    .pullup_i(pc_pullup_o), .ext_en_i(8'hff), .ext_val_i(ext[23:16]),
    .pin_o(pc_pin_i));
  // ***********
  // bus tasks
  // ***********
  task automatic print_verdict();
    if (fail_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    address_i <= a; read_i <= !w; write_i <= w;
    writedata_i <= {24'h0, d}; byteenable_i <= 4'h1;
    do begin @(posedge ref_clk_i); n++; end
    while (waitrequest_o !== 1'b0 && n < 20);
    q = readdata_o[7:0];
    read_i <= 1'b0; write_i <= 1'b0;
    if (n >= 20) begin fail_count++; print_verdict(); end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    `CHK(q, e)
  endtask
  // ***********
  // scenarios
  // ***********
  initial begin
    logic [5:0] b;
    logic [7:0] m, nc, np;
    logic lc, lp, n0, n1;
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    for (int p = 0; p < 3; p++) begin
      b = 6'(32 - 16 * p);
      m = (p == 0) ? 8'haf : 8'hff;
      rd(b, ext[p*8+:8]);
      rd(b + 6'h04, 8'h00);
      rd(b + 6'h08, 8'h00);
      wr(b + 6'h04, 8'h5a); wr(b + 6'h08, 8'hf3); wr(b, 8'h96);
      repeat (4) @(posedge ref_clk_i);
      `CHK(oe_all[p*8+:8], 8'h5a & ((8'hf3 & m) | ~8'h96))
      `CHK(pu_all[p*8+:8], ~8'h5a & 8'hf3 & m)
      `CHK(out_all[p*8+:8] & 8'h5a & 8'hf3 & m, 8'h12 & m)
      rd(b, (8'h96 & 8'h5a) | (ext[p*8+:8] & ~8'h5a));
      rd(b + 6'h04, 8'h5a);
      rd(b + 6'h08, 8'hf3 & m);
    end
    rd(6'h30, 8'h00);
    wr(6'h0c, 8'hff); rd(6'h0c, 8'h00);
    irq_masked_i <= 1'b0;
    wr(6'h30, 8'hff); rd(6'h30, 8'h27);
    irq_masked_i <= 1'b1;
    wr(6'h30, 8'hd8); rd(6'h30, 8'hd8);
    foreach (dv[k]) begin
      wr(6'h30, dv[k][7:0]);
      repeat (40) @(posedge ref_clk_i);
      nc = 0; np = 0; lc = cpu_clk_o; lp = pc_out_o[2];
      repeat (64) begin
        @(posedge ref_clk_i);
        nc += 8'(cpu_clk_o != lc); np += 8'(pc_out_o[2] != lp);
        lc = cpu_clk_o; lp = pc_out_o[2];
      end
      `CHK(nc, dv[k][15:8])
      `CHK(np, dv[k][15:8])
    end
    wr(6'h24, 8'h00); wr(6'h28, 8'h01); wr(6'h14, 8'h00);
    wr(6'h18, 8'h01); wr(6'h04, 8'h00); wr(6'h08, 8'h00);
    for (int c = 0; c < 4; c++) begin
      ext[8] <= 1'b1; ext[0] <= 1'b1;
      wr(6'h30, {c[1:0], 1'b0, c[1:0], 3'b000});
      repeat (8) @(posedge ref_clk_i);
      for (int e = 0; e < 2; e++) begin
        ext[8] <= e[0]; ext[0] <= e[0];
        @(posedge ref_clk_i);
        n0 = 1'b0; n1 = 1'b0;
        repeat (8) begin @(posedge ref_clk_i); n0 |= irq0; n1 |= irq1; end
        `CHK({n1, n0}, {2{e ? c[0] : c != 1}})
      end
    end
    wr(6'h28, 8'h00); wr(6'h18, 8'h00); wr(6'h08, 8'h01);
    for (int s = 0; s < 2; s++) begin
      src <= s[0]; ext[16] <= 1'b1; repeat (8) @(posedge ref_clk_i);
      ext[16] <= 1'b0;
      @(posedge ref_clk_i);
      n0 = 1'b0; n1 = 1'b0;
      repeat (8) begin @(posedge ref_clk_i); n0 |= irq0; n1 |= irq1; end
      `CHK({n1, n0}, s ? 2'b10 : 2'b01)
    end
    wr(6'h34, 8'hff); rd(6'h34, 8'h0f);
    wr(6'h34, 8'h02); repeat (4) @(posedge ref_clk_i);
    `CHK(spi_select_level_o, 1'b0)
    for (int e = 0; e < 2; e++) begin
      ext[15] <= e[0]; wr(6'h34, 8'h00); repeat (4) @(posedge ref_clk_i);
      `CHK(spi_select_level_o, e[0])
    end
    spi <= 4'hf; wr(6'h34, 8'h00); repeat (4) @(posedge ref_clk_i);
    `CHK({pb_oe_o[5:4], pb_out_o[5:4]}, 4'hf)
    wr(6'h34, 8'h0c); repeat (4) @(posedge ref_clk_i);
    `CHK(pb_oe_o[5:4], 2'b00)
    print_verdict();
  end
endmodule // tb
